// file: hdl/lsi_host.sv
// host controller: avalon register slave and serial master for the supply chip
`include "lsi_regs.svh"
module lsi_host
	import lsi_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic [1:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);
	lsi_state_t  st_r;
	logic [1:0]  ph_r;
	logic [3:0]  bitcnt_r;
	logic [7:0]  shreg_r;
	logic        rx_r;
	logic        addr_r;
	logic [2:0]  left_r;
	logic [7:0]  data_r;
	logic        rw_r;
	logic        asel_r;
	logic        fast_r;
	logic        skip_r;
	logic [2:0]  cnt_r;
	logic        go_r;
	logic        busy_r;
	logic        nack_r;
	logic        done_r;
	logic [15:0] rdata_r;
	logic        scl_s;
	logic        sda_s;
	logic        tick;
	logic        adv;
	logic        take;
	logic        ack_ok;
	logic        scl_oe_nxt;
	logic        sda_oe_nxt;
	logic [31:0] rd_nxt;
	logic        ack_end;
	logic        bit_end;
	logic        nack_seen;

	// pin inputs cross into the clk domain
	lsi_sync #(.W(2)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.din    ({scl_i, sda_i}),
		.dout   ({scl_s, sda_s})
	);

	// quarter-bit timing, rate from the command register
	lsi_tick u_tick (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.fast   (fast_r),
		.tick   (tick)
	);

	assign adv  = tick & ce;
	assign take = ce & ~avs_waitrequest & (avs_read | avs_write);
	// skip option accepts a missing acknowledge
	assign ack_ok  = ~sda_s | skip_r;
	assign bit_end = adv && st_r == LSI_BYTE && ph_r == `LSI_PH_SAMPLE;
	assign ack_end = bit_end && bitcnt_r == `LSI_ACK_BIT;
	assign nack_seen = ack_end && !rx_r && !ack_ok;

	// avalon handshake: one wait cycle, then a one-cycle answer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
		end
	end

	// read mux; unmapped words read zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (avs_address)
			`LSI_REG_CMD: begin
				rd_nxt[`LSI_CMD_DATA_HI:`LSI_CMD_DATA_LO] = data_r;
				rd_nxt[`LSI_CMD_RW]   = rw_r;
				rd_nxt[`LSI_CMD_ASEL] = asel_r;
				rd_nxt[`LSI_CMD_FAST] = fast_r;
				rd_nxt[`LSI_CMD_SKIP] = skip_r;
				rd_nxt[`LSI_CMD_CNT_HI:`LSI_CMD_CNT_LO] = cnt_r;
			end
			`LSI_REG_STAT: begin
				rd_nxt[`LSI_ST_BUSY] = busy_r | go_r;
				rd_nxt[`LSI_ST_NACK] = nack_r;
				rd_nxt[`LSI_ST_FREE] = scl_s & sda_s;
				rd_nxt[`LSI_ST_DONE] = done_r;
			end
			`LSI_REG_RDATA: begin
				rd_nxt[15:0] = rdata_r;
			end
			default: begin
				rd_nxt = 32'h0000_0000;
			end
		endcase
	end

	// read data stands during the answer cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (ce) begin
			avs_readdata <= rd_nxt;
		end
	end

	// command register; writes while busy are dropped to keep a frame intact
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_r <= `LSI_RST_BYTE;
			rw_r   <= 1'b0;
			asel_r <= 1'b0;
			fast_r <= 1'b0;
			skip_r <= 1'b0;
			cnt_r  <= 3'h0;
			go_r   <= 1'b0;
		end else if (ce) begin
			go_r <= 1'b0;
			if (take && avs_write && avs_address == `LSI_REG_CMD && !busy_r && !go_r) begin
				data_r <= avs_writedata[`LSI_CMD_DATA_HI:`LSI_CMD_DATA_LO];
				rw_r   <= avs_writedata[`LSI_CMD_RW];
				asel_r <= avs_writedata[`LSI_CMD_ASEL];
				fast_r <= avs_writedata[`LSI_CMD_FAST];
				skip_r <= avs_writedata[`LSI_CMD_SKIP];
				cnt_r  <= avs_writedata[`LSI_CMD_CNT_HI:`LSI_CMD_CNT_LO];
				go_r   <= avs_writedata[`LSI_CMD_GO];
			end
		end
	end

	// frame sequencer: wait free, start, address, data bytes, stop
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r     <= LSI_IDLE;
			ph_r     <= `LSI_PH_HOLD;
			bitcnt_r <= 4'h0;
			shreg_r  <= 8'h00;
			rx_r     <= 1'b0;
			addr_r   <= 1'b0;
			left_r   <= 3'h0;
		end else if (ce) begin
			case (st_r)
				LSI_IDLE: begin
					ph_r <= `LSI_PH_HOLD;
					if (go_r) begin
						st_r   <= LSI_FREE;
						left_r <= cnt_r;
					end
				end
				LSI_FREE: begin
					// start only on an idle bus
					if (adv && scl_s && sda_s) begin
						st_r <= LSI_START;
					end
				end
				LSI_START: begin
					if (adv) begin
						ph_r <= ph_r + 2'h1;
						if (ph_r == `LSI_PH_SAMPLE) begin
							st_r     <= LSI_BYTE;
							bitcnt_r <= 4'h0;
							shreg_r  <= {`LSI_ADDR_BASE, asel_r, rw_r};
							rx_r     <= 1'b0;
							addr_r   <= 1'b1;
						end
					end
				end
				LSI_BYTE: begin
					// a stretched clock holds the rise phase
					if (adv && !(ph_r == `LSI_PH_RISE && !scl_s)) begin
						ph_r <= ph_r + 2'h1;
					end
					// msb-first shift, ninth bit is acknowledge
					if (bit_end && bitcnt_r != `LSI_ACK_BIT) begin
						shreg_r  <= rx_r ? {shreg_r[6:0], sda_s} : {shreg_r[6:0], 1'b0};
						bitcnt_r <= bitcnt_r + 4'h1;
					end
					if (ack_end) begin
						bitcnt_r <= 4'h0;
						addr_r   <= 1'b0;
						if (nack_seen) begin
							st_r <= LSI_STOP;
						end else if (addr_r && rw_r) begin
							rx_r <= 1'b1;
						end else if (addr_r) begin
							shreg_r <= data_r;
						end else if (rx_r && left_r != 3'h0) begin
							left_r <= left_r - 3'h1;
						end else begin
							st_r <= LSI_STOP;
						end
					end
				end
				LSI_STOP: begin
					if (adv) begin
						ph_r <= ph_r + 2'h1;
						if (ph_r == `LSI_PH_SAMPLE) begin
							st_r <= LSI_IDLE;
						end
					end
				end
				default: begin
					st_r <= LSI_IDLE;
				end
			endcase
		end
	end

	// status flags and received bytes; nack and done cleared when a new frame is launched, received bytes only by reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy_r  <= 1'b0;
			nack_r  <= 1'b0;
			done_r  <= 1'b0;
			rdata_r <= 16'h0000;
		end else if (ce) begin
			busy_r <= (st_r != LSI_IDLE) | go_r;
			if (go_r) begin
				nack_r <= 1'b0;
				done_r <= 1'b0;
			end
			if (nack_seen) begin
				nack_r <= 1'b1;
			end
			if (ack_end && rx_r) begin
				rdata_r <= {rdata_r[7:0], shreg_r};
			end
			if (adv && st_r == LSI_STOP && ph_r == `LSI_PH_SAMPLE) begin
				done_r <= 1'b1;
			end
		end
	end

	// pin drive from sequencer state; enable high pulls the line low
	always_comb begin
		scl_oe_nxt = 1'b0;
		sda_oe_nxt = sda_oe;
		case (st_r)
			LSI_IDLE, LSI_FREE: begin
				// both lines released outside a frame
				sda_oe_nxt = 1'b0;
			end
			LSI_START: begin
				// data falls while clock is high
				scl_oe_nxt = (ph_r >= `LSI_PH_RISE);
				sda_oe_nxt = (ph_r != `LSI_PH_HOLD);
			end
			LSI_BYTE: begin
				scl_oe_nxt = (ph_r <= `LSI_PH_SET);
				// data set only in the low phase
				if (ph_r == `LSI_PH_SET) begin
					if (bitcnt_r != `LSI_ACK_BIT) begin
						sda_oe_nxt = ~rx_r & ~shreg_r[7];
					end else begin
						sda_oe_nxt = rx_r & (left_r != 3'h0);
					end
				end
			end
			LSI_STOP: begin
				// data rises while clock is high
				scl_oe_nxt = (ph_r <= `LSI_PH_SET);
				if (ph_r == `LSI_PH_SET || ph_r == `LSI_PH_RISE) begin
					sda_oe_nxt = 1'b1;
				end else if (ph_r == `LSI_PH_SAMPLE) begin
					sda_oe_nxt = 1'b0;
				end
			end
			default: begin
				sda_oe_nxt = 1'b0;
			end
		endcase
	end

	// open-drain pins: data outputs stay low, only enables move
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			scl_o  <= 1'b0;
			sda_o  <= 1'b0;
		end else if (ce) begin
			scl_oe <= scl_oe_nxt;
			sda_oe <= sda_oe_nxt;
			scl_o  <= 1'b0;
			sda_o  <= 1'b0;
		end
	end

	// checks on the driven pins and sequencer
	sequence s_idle2;
		(st_r == LSI_IDLE) [*2];
	endsequence

	property p_idle_release;
		@(posedge clk) disable iff (!resetn)
		s_idle2 |-> !scl_oe && !sda_oe;
	endproperty
	a_idle_release: assert property (p_idle_release)
		else $error("lines not released while idle");

	property p_data_low_clock;
		@(posedge clk) disable iff (!resetn)
		(st_r == LSI_BYTE && $changed(sda_oe)) |-> scl_oe && $past(scl_oe);
	endproperty
	a_data_low_clock: assert property (p_data_low_clock)
		else $error("data changed while clock high");

	property p_start_cond;
		@(posedge clk) disable iff (!resetn)
		(st_r == LSI_START && $rose(sda_oe)) |-> !scl_oe;
	endproperty
	a_start_cond: assert property (p_start_cond)
		else $error("start not made with clock high");

	property p_stop_only;
		@(posedge clk) disable iff (!resetn)
		($fell(sda_oe) && !scl_oe) |-> $past(st_r) == LSI_STOP;
	endproperty
	a_stop_only: assert property (p_stop_only)
		else $error("data released with clock high outside stop");

	property p_bit_step;
		@(posedge clk) disable iff (!resetn)
		$past(bit_end) |-> (bitcnt_r == $past(bitcnt_r) + 4'h1) || (bitcnt_r == 4'h0);
	endproperty
	a_bit_step: assert property (p_bit_step)
		else $error("bit counter skipped");

	property p_nack_stop;
		@(posedge clk) disable iff (!resetn)
		$past(nack_seen) |-> st_r == LSI_STOP && nack_r;
	endproperty
	a_nack_stop: assert property (p_nack_stop)
		else $error("no stop after missing acknowledge");

	property p_read_ack;
		@(posedge clk) disable iff (!resetn)
		(st_r == LSI_BYTE && rx_r && bitcnt_r == `LSI_ACK_BIT && ph_r == `LSI_PH_SAMPLE)
			|-> sda_oe == (left_r != 3'h0);
	endproperty
	a_read_ack: assert property (p_read_ack)
		else $error("wrong master acknowledge on read");

	property p_addr_byte;
		@(posedge clk) disable iff (!resetn)
		(st_r == LSI_BYTE && $past(st_r) == LSI_START)
			|-> shreg_r == {`LSI_ADDR_BASE, asel_r, rw_r};
	endproperty
	a_addr_byte: assert property (p_addr_byte)
		else $error("address byte or direction wrong");
endmodule

// file: hdl/lsi_regs.svh
// register map, field positions and timing constants of the supply-link host
`ifndef LSI_REGS_SVH
`define LSI_REGS_SVH

// register word indices on the avalon slave
`define LSI_REG_CMD     2'h0
`define LSI_REG_STAT    2'h1
`define LSI_REG_RDATA   2'h2

// command register fields
`define LSI_CMD_DATA_HI 7
`define LSI_CMD_DATA_LO 0
`define LSI_CMD_RW      8
`define LSI_CMD_ASEL    9
`define LSI_CMD_FAST    10
`define LSI_CMD_SKIP    11
`define LSI_CMD_GO      12
`define LSI_CMD_CNT_HI  15
`define LSI_CMD_CNT_LO  13

// status register fields
`define LSI_ST_BUSY     0
`define LSI_ST_NACK     1
`define LSI_ST_FREE     2
`define LSI_ST_DONE     3

// fixed upper six address bits of the device
`define LSI_ADDR_BASE   6'h04
`define LSI_RST_BYTE    8'h00
`define LSI_ACK_BIT     4'h8

// quarter-bit phases of one serial bit
`define LSI_PH_HOLD     2'h0
`define LSI_PH_SET      2'h1
`define LSI_PH_RISE     2'h2
`define LSI_PH_SAMPLE   2'h3

// bit periods in ns and their quarter counts, rounded up to stay below rate
`define LSI_CLK_NS      40
`define LSI_STD_BIT_NS  10000
`define LSI_FAST_BIT_NS 2500
`define LSI_STD_QTR  ((`LSI_STD_BIT_NS + 4*`LSI_CLK_NS - 1) / (4*`LSI_CLK_NS))
`define LSI_FAST_QTR ((`LSI_FAST_BIT_NS + 4*`LSI_CLK_NS - 1) / (4*`LSI_CLK_NS))

`endif

// file: hdl/lsi_pkg.sv
// types shared by the supply-link host
package lsi_pkg;
	typedef enum logic [2:0] {
		LSI_IDLE  = 3'b000,
		LSI_FREE  = 3'b001,
		LSI_START = 3'b010,
		LSI_BYTE  = 3'b011,
		LSI_STOP  = 3'b100
	} lsi_state_t;
endpackage

// file: hdl/lsi_sync.sv
// two-flop synchronisers for pin inputs
module lsi_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	// first stage is read only by the second; lines idle high
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_r;
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				meta_r  <= 1'b1;
				dout[i] <= 1'b1;
			end else if (ce) begin
				meta_r  <= din[i];
				dout[i] <= meta_r;
			end
		end
	end
endmodule

// file: hdl/lsi_tick.sv
// quarter-bit tick generator for the serial clock
`include "lsi_regs.svh"
module lsi_tick (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic fast,
	output logic      tick
);
	logic [6:0] cnt_r;
	logic [6:0] last;

	assign last = fast ? 7'(`LSI_FAST_QTR - 1) : 7'(`LSI_STD_QTR - 1);

	// free-running divider, one-cycle tick at wrap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 7'h00;
			tick  <= 1'b0;
		end else if (ce) begin
			if (cnt_r >= last) begin
				cnt_r <= 7'h00;
				tick  <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 7'h01;
				tick  <= 1'b0;
			end
		end
	end
endmodule

// file: tb/lsi_dev_model.sv
// behavioural supply regulator on the serial bus with its two control registers
module lsi_dev_model (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic asel,
	input  wire logic pg,
	input  wire logic ovl,
	input  wire logic ovt,
	input  wire logic tgate,
	output logic      oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] r1, r2, sh, tx;
	logic       act, adr, hit, rd, sel, tone, clamp;
	int         n, lvl, lim;
	// supply decode; output off forces all off
	always @* begin
		lvl = r1[1] ? 13 + (r1[2] ? 5 : 0) + (r1[3] ? 1 : 0) : 0;
		lim = r1[1] ? (r1[5] ? 775 : 425) : 0;
		clamp = r1[1] & r1[6];
		// continuous tone overrides the gate pin
		tone = r1[1] & (r1[4] | tgate);
	end
	initial begin
		r1 = 8'h00;
		r2 = 8'h00;
		sel = 1'b0;
		act = 1'b0;
		oe = 1'b0;
	end
	always @(pg or r1) if (!pg) begin
		r1 = 8'h00;
		r2 = 8'h00;
		sel = 1'b0;
	end
	always @(negedge sda) if (scl === 1'b1) begin
		act = 1'b1;
		adr = 1'b1;
		rd = 1'b0;
		n = 0;
		oe = 1'b0;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		act = 1'b0;
		oe = 1'b0;
	end
	// sample while clock high, msb first
	always @(posedge scl) if (act) begin
		if (n < 8)
			sh = {sh[6:0], sda};
		else if (rd && sda)
			hit = 1'b0;
		n = n + 1;
	end
	// only pulls low, changes while clock low
	always @(negedge scl) if (act) begin
		oe = 1'b0;
		if (n == 8 && adr) begin
			hit = pg && sh[7:1] == {6'h04, asel};
			rd = sh[0];
			oe = hit;
		end else if (n == 8 && !rd && hit && pg) begin
			sel = sh[7];
			if (sh[7])
				r2 = sh & 8'h04;
			else
				r1 = sh & 8'h7e;
			oe = 1'b1;
		end else if (n == 9) begin
			n = 0;
			adr = 1'b0;
			tx = sel ? (r2 | 8'h80 | {6'h00, ovt, 1'b0}) : (r1 | {7'h00, ovl});
		end
		if (n < 8 && rd && hit && !adr)
			oe = !tx[7 - n];
	end
endmodule

// file: tb/tb.sv
// self-checking bench for the supply-link host with a device model
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, resetn, ce, avs_read, avs_write, avs_waitrequest;
	logic [1:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic        scl_oe, sda_oe, dev_oe, scl_w, sda_w, asel, pg, ovl, ovt, msel, tg;
	logic [7:0]  m1, m2, lf;
	int          fails, samples_checked, rises, starts, stops, per, last, fz;
	// open-drain wires with pull-ups
	assign scl_w = !scl_oe;
	assign sda_w = !(sda_oe || dev_oe);
	lsi_host i_lsi_host (.clk(clk), .resetn(resetn), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_i(scl_w),
		.scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
	lsi_dev_model i_lsi_dev_model (.scl(scl_w), .sda(sda_w), .asel(asel), .pg(pg),
		.ovl(ovl), .ovt(ovt), .tgate(tg), .oe(dev_oe));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// wire monitor: clock rises, bit period, starts and stops
	always @(posedge scl_w) begin
		rises++;
		per = int'($time) - last;
		last = int'($time);
	end
	always @(negedge sda_w) if (scl_w) starts++;
	always @(posedge sda_w) if (scl_w) stops++;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [15:0] mk(input logic [2:0] c, input logic sk, input logic f,
		input logic a, input logic r, input logic [7:0] d);
		return {c, 1'b0, sk, f, a, r, d};
	endfunction
	// expected readback of the selected register
	function automatic logic [7:0] rv();
		return msel ? (m2 | 8'h80 | {6'h00, ovt, 1'b0}) : (m1 | {7'h00, ovl});
	endfunction
	// expected supply decode of the first register: level, limit, clamp, tone
	function automatic int sv();
		if (!m1[1])
			return 0;
		return (13 + (m1[2] ? 5 : 0) + (m1[3] ? 1 : 0)) * 65536
			+ (m1[5] ? 775 : 425) * 4 + m1[6] * 2 + (m1[4] | tg);
	endfunction
	// decode seen in the device model, packed the same way
	function automatic int dv();
		return i_lsi_dev_model.lvl * 65536 + i_lsi_dev_model.lim * 4
			+ i_lsi_dev_model.clamp * 2 + i_lsi_dev_model.tone;
	endfunction
	task automatic mw(input logic [7:0] d);
		msel = d[7];
		if (d[7])
			m2 = d & 8'h04;
		else
			m1 = d & 8'h7e;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one avalon access; request held until waitrequest is sampled low
	task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		// no cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// start a transfer, poll status until not busy; q ends as status
	task automatic xfer(input logic [15:0] c);
		int j;
		rises = 0;
		starts = 0;
		stops = 0;
		av(1'b1, 2'h0, {16'h0000, c | 16'h1000});
		// optional mid-frame freeze: clock enable low must only pause the frame
		if (fz > 0) begin
			repeat (fz) @(posedge clk);
			ce <= 1'b0;
			repeat (fz) @(posedge clk);
			ce <= 1'b1;
		end
		j = 0;
		do begin
			av(1'b0, 2'h1, 32'h0);
			j++;
		end while (q[0] !== 1'b0 && j < 4000);
	endtask
	task automatic rdchk();
		xfer(mk(3'h0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00));
		av(1'b0, 2'h2, 32'h0);
		chk(q[7:0], rv()); // readback
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// watchdog: about twice the traffic of all scenarios, under 100k cycles
	initial begin
		#3ms;
		fails++;
		tally_and_finish();
	end
	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{asel, ovl, ovt, msel, m1, m2, tg} = '0;
		fz = 0;
		pg = 1'b1;
		lf = 8'h62;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		av(1'b0, 2'h1, 32'h0);
		chk(q[3:0], 4'h4); // idle bus free
		av(1'b0, 2'h3, 32'h0);
		chk(q, 32'h0); // unmapped reads zero
		xfer(mk(3'h1, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00));
		chk(q[3:0], 4'hc); // read done
		chk(rises * 256 + starts * 16 + stops, 28 * 256 + 17);
		chk(per, 2560); // fast bit period
		av(1'b0, 2'h2, 32'h0);
		chk(q[15:0], {rv(), rv()}); // cleared
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			ovl <= lf[0];
			ovt <= lf[3];
			tg <= lf[1];
			xfer(mk(3'h0, 1'b0, 1'b1, 1'b0, 1'b0, lf));
			mw(lf);
			chk(q[3:0] + rises * 16, 4'hc + 19 * 16); // acked write
			rdchk(); // selector
			chk(dv(), sv()); // supply decode
		end
		xfer(mk(3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h55));
		chk(q[3:0] + rises * 16, 4'he + 10 * 16); // wrong address
		asel <= 1'b1;
		fz = 300;
		xfer(mk(3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h86));
		fz = 0;
		mw(8'h86);
		chk(q[3:0] + rises * 16, 4'hc + 19 * 16); // other address, frozen
		asel <= 1'b0;
		pg <= 1'b0;
		xfer(mk(3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h7e));
		{msel, m1, m2} = '0;
		chk(q[3:0], 4'he); // no ack in lockout
		chk(dv(), sv()); // lockout keeps supply off
		xfer(mk(3'h0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h7e));
		chk(q[3:0] + rises * 16, 4'hc + 19 * 16); // unchecked ack
		pg <= 1'b1;
		rdchk(); // still zero
		xfer(mk(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h1e));
		mw(8'h1e);
		chk(per, 10080); // standard bit period
		chk(dv(), sv()); // standard write decode
		av(1'b0, 2'h0, 32'h0);
		chk(q, 32'h0000_001e); // command readback, go reads zero
		rdchk(); // standard write
		tally_and_finish();
	end
endmodule
